// ==== include/dsec_pkg.sv ====
// package for the descrambler and error-character register bank
package dsec_pkg;

  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned CHAR_W = 10;
  localparam int unsigned NUM_FIFO = 3;

  // register addresses on the management port
  localparam logic [15:0] ADDR_SEED_HIGH = 16'h801C;
  localparam logic [15:0] ADDR_SEED_LOW  = 16'h801D;
  localparam logic [15:0] ADDR_POLY_HIGH = 16'h801E;
  localparam logic [15:0] ADDR_POLY_LOW  = 16'h801F;
  localparam logic [15:0] ADDR_LINK_CTRL = 16'h8021;
  localparam logic [15:0] ADDR_SLOW_TX   = 16'h8026;
  localparam logic [15:0] ADDR_SLOW_RX   = 16'h8027;
  localparam logic [15:0] ADDR_FAST_RX   = 16'h8028;

  // reset values
  localparam logic [15:0] RST_SEED_HIGH = 16'h0000;
  localparam logic [15:0] RST_SEED_LOW  = 16'h01FC;
  localparam logic [15:0] RST_POLY_HIGH = 16'h0000;
  localparam logic [15:0] RST_POLY_LOW  = 16'h00C0;
  localparam logic [15:0] RST_LINK_CTRL = 16'h000A;
  localparam logic [9:0]  RST_ERR_CHAR  = 10'h2FE;

  // field positions in the link check control register
  localparam int unsigned BIT_PLL_CHECK_OFF = 6;
  localparam int unsigned BIT_LOS_CHECK_OFF = 5;
  localparam int unsigned BIT_CLK_FLATLINE  = 3;
  localparam int unsigned BIT_FORCED_ZERO   = 0;

  localparam logic [15:0] READ_ZERO = 16'h0000;

  // fifo index order for the error-character substitution
  localparam int unsigned FIFO_SLOW_TX = 0;
  localparam int unsigned FIFO_SLOW_RX = 1;
  localparam int unsigned FIFO_FAST_RX = 2;

  typedef struct packed {
    logic              write;
    logic              read;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } dsec_mgmt_req_type;

  typedef struct packed {
    logic              valid;
    logic [DATA_W-1:0] rdata;
  } dsec_mgmt_rsp_type;

  typedef struct packed {
    logic              error;
    logic [CHAR_W-1:0] data;
  } dsec_char_type;

endpackage

// ==== rtl/dsec_char_subst.sv ====
// substitutes the programmed error character on a fifo that flags an error
`timescale 1ns/1ns
`default_nettype none
module dsec_char_subst (
  input  wire logic                         clk_sys,
  input  wire logic                         rst_n,
  input  wire dsec_pkg::dsec_char_type      char_in,
  input  wire logic [dsec_pkg::CHAR_W-1:0]  error_char,
  output logic      [dsec_pkg::CHAR_W-1:0]  char_out
);

  logic [dsec_pkg::CHAR_W-1:0] next_char_out;

  // per-character choice, registered, so normal data resumes the cycle after the error clears
  assign next_char_out = char_in.error ? error_char : char_in.data; // R15

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      char_out <= '0;
    end else begin
      char_out <= next_char_out;
    end
  end

endmodule
`default_nettype wire

// ==== rtl/dsec_regs.sv ====
// management register bank: descrambler seed/polynomial, link checks, error chars
//
// Overview of operation
// R1: seed split over 0x801C high, 0x801D low
// R2: host must program a non-zero seed
// R3: seed bit 0 always reads zero
// R4: seed resets to 0x0000 and 0x01FC
// R5: polynomial at 0x801E/0x801F, resets 0x0000/0x00C0
// R6: polynomial bit 0 always reads zero
// R7: bit 6 set skips pll lock check
// R8: bit 5 set skips loss-of-signal check
// R9: bit 3 flatlines recovered clock on signal loss
// R10: slow-side tx fifo error sends char 0x8026
// R11: slow-side rx fifo error sends char 0x8027
// R12: fast-side rx fifo error sends char 0x8028
// R13: control resets 0x000A, reserved bits stay writable
// R14: seed feeds thirty-two-bit post-decoder descrambler
// R15: substitute error char while fifo flags error
// R16: host preserves reserved bits on writes
`timescale 1ns/1ns
`default_nettype none
module dsec_regs (
  input  wire logic                        clk_sys,
  input  wire logic                        rst_n,
  input  wire dsec_pkg::dsec_mgmt_req_type mgmt_req,
  output dsec_pkg::dsec_mgmt_rsp_type      mgmt_rsp,
  input  wire logic                        fast_pll_locked,
  input  wire logic                        fast_signal_lost,
  input  wire logic                        clock_output_is_recovered,
  input  wire dsec_pkg::dsec_char_type     slow_tx_char_in,
  input  wire dsec_pkg::dsec_char_type     slow_rx_char_in,
  input  wire dsec_pkg::dsec_char_type     fast_rx_char_in,
  output logic [dsec_pkg::CHAR_W-1:0]      slow_tx_char_out,
  output logic [dsec_pkg::CHAR_W-1:0]      slow_rx_char_out,
  output logic [dsec_pkg::CHAR_W-1:0]      fast_rx_char_out,
  output logic [31:0]                      rx_descrambler_seed,
  output logic [31:0]                      rx_descrambler_polynomial,
  output logic                             fast_link_ready,
  output logic                             clock_output_hold,
  output logic [dsec_pkg::DATA_W-1:0]      link_check_reserved
);

  ////////////////////////////////////////////////////////////////////////////
  logic [15:0] rx_descrambler_seed_high;
  logic [15:0] rx_descrambler_seed_low;
  logic [15:0] rx_descrambler_poly_high;
  logic [15:0] rx_descrambler_poly_low;
  logic [15:0] link_check_control;
  logic [dsec_pkg::CHAR_W-1:0] low_side_tx_error_char;
  logic [dsec_pkg::CHAR_W-1:0] low_side_rx_error_char;
  logic [dsec_pkg::CHAR_W-1:0] high_side_rx_error_char;

  wire         wr_seed_high = mgmt_req.write && mgmt_req.addr == dsec_pkg::ADDR_SEED_HIGH;
  wire         wr_seed_low  = mgmt_req.write && mgmt_req.addr == dsec_pkg::ADDR_SEED_LOW;
  wire         wr_poly_high = mgmt_req.write && mgmt_req.addr == dsec_pkg::ADDR_POLY_HIGH;
  wire         wr_poly_low  = mgmt_req.write && mgmt_req.addr == dsec_pkg::ADDR_POLY_LOW;
  wire         wr_link_ctrl = mgmt_req.write && mgmt_req.addr == dsec_pkg::ADDR_LINK_CTRL;
  wire         wr_slow_tx   = mgmt_req.write && mgmt_req.addr == dsec_pkg::ADDR_SLOW_TX;
  wire         wr_slow_rx   = mgmt_req.write && mgmt_req.addr == dsec_pkg::ADDR_SLOW_RX;
  wire         wr_fast_rx   = mgmt_req.write && mgmt_req.addr == dsec_pkg::ADDR_FAST_RX;

  // bit 0 is cleared on the way in, so storage and readback agree
  wire  [15:0] wdata_lsb_clear = {mgmt_req.wdata[15:1], 1'b0}; // R3 R6
  wire  [dsec_pkg::CHAR_W-1:0] wdata_char = mgmt_req.wdata[dsec_pkg::CHAR_W-1:0];

  // next values per register; the char registers keep bits 9:0 only
  wire  [15:0]                 next_seed_high    = mgmt_req.wdata;
  wire  [15:0]                 next_seed_low     = wdata_lsb_clear; // R3
  wire  [15:0]                 next_poly_high    = mgmt_req.wdata;
  wire  [15:0]                 next_poly_low     = wdata_lsb_clear; // R6
  wire  [15:0]                 next_link_ctrl    = mgmt_req.wdata;
  wire  [dsec_pkg::CHAR_W-1:0] next_slow_tx_char = wdata_char;
  wire  [dsec_pkg::CHAR_W-1:0] next_slow_rx_char = wdata_char;
  wire  [dsec_pkg::CHAR_W-1:0] next_fast_rx_char = wdata_char;

  ////////////////////////////////////////////////////////////////////////////
  // one short process per register keeps each write decode visible
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rx_descrambler_seed_high <= dsec_pkg::RST_SEED_HIGH; // R4
    end else if (wr_seed_high) begin
      rx_descrambler_seed_high <= next_seed_high; // R1
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rx_descrambler_seed_low <= dsec_pkg::RST_SEED_LOW; // R4
    end else if (wr_seed_low) begin
      rx_descrambler_seed_low <= next_seed_low; // R1 R3
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rx_descrambler_poly_high <= dsec_pkg::RST_POLY_HIGH; // R5
    end else if (wr_poly_high) begin
      rx_descrambler_poly_high <= next_poly_high; // R5
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rx_descrambler_poly_low <= dsec_pkg::RST_POLY_LOW; // R5
    end else if (wr_poly_low) begin
      rx_descrambler_poly_low <= next_poly_low; // R5 R6
    end
  end

  // reserved bits are plain storage; nothing here guards them
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      link_check_control <= dsec_pkg::RST_LINK_CTRL; // R13
    end else if (wr_link_ctrl) begin
      link_check_control <= next_link_ctrl; // R13
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      low_side_tx_error_char <= dsec_pkg::RST_ERR_CHAR; // R10
    end else if (wr_slow_tx) begin
      low_side_tx_error_char <= next_slow_tx_char; // R10
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      low_side_rx_error_char <= dsec_pkg::RST_ERR_CHAR; // R11
    end else if (wr_slow_rx) begin
      low_side_rx_error_char <= next_slow_rx_char; // R11
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      high_side_rx_error_char <= dsec_pkg::RST_ERR_CHAR; // R12
    end else if (wr_fast_rx) begin
      high_side_rx_error_char <= next_fast_rx_char; // R12
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read decode; unmapped addresses answer zero
  logic [15:0] read_mux;
  always_comb begin
    unique case (mgmt_req.addr)
      dsec_pkg::ADDR_SEED_HIGH: read_mux = rx_descrambler_seed_high;
      dsec_pkg::ADDR_SEED_LOW:  read_mux = rx_descrambler_seed_low;
      dsec_pkg::ADDR_POLY_HIGH: read_mux = rx_descrambler_poly_high;
      dsec_pkg::ADDR_POLY_LOW:  read_mux = rx_descrambler_poly_low;
      dsec_pkg::ADDR_LINK_CTRL: read_mux = link_check_control;
      dsec_pkg::ADDR_SLOW_TX:   read_mux = {6'h00, low_side_tx_error_char};
      dsec_pkg::ADDR_SLOW_RX:   read_mux = {6'h00, low_side_rx_error_char};
      dsec_pkg::ADDR_FAST_RX:   read_mux = {6'h00, high_side_rx_error_char};
      default:                  read_mux = dsec_pkg::READ_ZERO;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mgmt_rsp <= '0;
    end else begin
      mgmt_rsp.valid <= mgmt_req.read;
      mgmt_rsp.rdata <= mgmt_req.read ? read_mux : dsec_pkg::READ_ZERO;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  wire pll_check_off  = link_check_control[dsec_pkg::BIT_PLL_CHECK_OFF];
  wire los_check_off  = link_check_control[dsec_pkg::BIT_LOS_CHECK_OFF];
  wire clock_flatline = link_check_control[dsec_pkg::BIT_CLK_FLATLINE];

  // a disabled check counts as always passing
  wire next_fast_link_ready = (pll_check_off || fast_pll_locked) // R7
                           && (los_check_off || !fast_signal_lost); // R8
  wire next_clock_output_hold = clock_flatline && clock_output_is_recovered
                             && fast_signal_lost; // R9

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fast_link_ready <= 1'b0;
    end else begin
      fast_link_ready <= next_fast_link_ready; // R7 R8
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      clock_output_hold <= 1'b0;
    end else begin
      clock_output_hold <= next_clock_output_hold; // R9
    end
  end

  // seed goes to the post-decoder descrambler; no zero-seed guard, host's duty
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rx_descrambler_seed <= {dsec_pkg::RST_SEED_HIGH, dsec_pkg::RST_SEED_LOW};
    end else begin
      rx_descrambler_seed <= {rx_descrambler_seed_high, rx_descrambler_seed_low}; // R14
    end
  end

  // halves are not written atomically, so a mixed value can show for a while
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rx_descrambler_polynomial <= {dsec_pkg::RST_POLY_HIGH, dsec_pkg::RST_POLY_LOW};
    end else begin
      rx_descrambler_polynomial <= {rx_descrambler_poly_high, rx_descrambler_poly_low}; // R5
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      link_check_reserved <= dsec_pkg::RST_LINK_CTRL;
    end else begin
      link_check_reserved <= link_check_control; // R13
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  dsec_pkg::dsec_char_type     fifo_in  [dsec_pkg::NUM_FIFO];
  logic [dsec_pkg::CHAR_W-1:0] fifo_chr [dsec_pkg::NUM_FIFO];
  logic [dsec_pkg::CHAR_W-1:0] fifo_out [dsec_pkg::NUM_FIFO];

  assign fifo_in[dsec_pkg::FIFO_SLOW_TX]  = slow_tx_char_in;
  assign fifo_in[dsec_pkg::FIFO_SLOW_RX]  = slow_rx_char_in;
  assign fifo_in[dsec_pkg::FIFO_FAST_RX]  = fast_rx_char_in;
  assign fifo_chr[dsec_pkg::FIFO_SLOW_TX] = low_side_tx_error_char;  // R10
  assign fifo_chr[dsec_pkg::FIFO_SLOW_RX] = low_side_rx_error_char;  // R11
  assign fifo_chr[dsec_pkg::FIFO_FAST_RX] = high_side_rx_error_char; // R12

  for (genvar i = 0; i < dsec_pkg::NUM_FIFO; i++) begin : g_subst
    dsec_char_subst u_subst (
      .clk_sys    (clk_sys),
      .rst_n      (rst_n),
      .char_in    (fifo_in[i]),
      .error_char (fifo_chr[i]),
      .char_out   (fifo_out[i])
    );
  end

  assign slow_tx_char_out = fifo_out[dsec_pkg::FIFO_SLOW_TX];
  assign slow_rx_char_out = fifo_out[dsec_pkg::FIFO_SLOW_RX];
  assign fast_rx_char_out = fifo_out[dsec_pkg::FIFO_FAST_RX];

endmodule
`default_nettype wire

// ==== testbench/dsec_regs_checker.sv ====
// assertion checker on the register bank ports
`timescale 1ns/1ns
`default_nettype none
module dsec_regs_checker (
  input wire logic                        clk_sys,
  input wire logic                        rst_n,
  input wire dsec_pkg::dsec_mgmt_req_type mgmt_req,
  input wire dsec_pkg::dsec_mgmt_rsp_type mgmt_rsp,
  input wire logic                        fast_pll_locked,
  input wire logic                        fast_signal_lost,
  input wire logic                        clock_output_is_recovered,
  input wire dsec_pkg::dsec_char_type     slow_tx_char_in,
  input wire logic [9:0]                  slow_tx_char_out,
  input wire logic [31:0]                 rx_descrambler_seed,
  input wire logic [31:0]                 rx_descrambler_polynomial,
  input wire logic                        fast_link_ready,
  input wire logic                        clock_output_hold,
  input wire logic [15:0]                 link_check_reserved
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_read_answered: assert property (mgmt_req.read |=> mgmt_rsp.valid)
    else $error("read not answered");
  a_idle_quiet: assert property (
    !mgmt_req.read |=> !mgmt_rsp.valid && mgmt_rsp.rdata == 16'h0000)
    else $error("answer without read");
  a_seed_bit_clear: assert property (rx_descrambler_seed[0] == 1'b0)
    else $error("seed bit 0 set");
  a_poly_bit_clear: assert property (rx_descrambler_polynomial[0] == 1'b0)
    else $error("polynomial bit 0 set");
  a_pll_check_runs: assert property (
    $past(!fast_pll_locked) && !link_check_reserved[6] |-> !fast_link_ready)
    else $error("ready without pll lock");
  a_loss_check_runs: assert property (
    $past(fast_signal_lost) && !link_check_reserved[5] |-> !fast_link_ready)
    else $error("ready during signal loss");
  a_checks_skipped: assert property (link_check_reserved[6] && link_check_reserved[5] |-> fast_link_ready)
    else $error("ready low with checks off");
  a_clock_flat: assert property (
    $past(rst_n) && $past(fast_signal_lost && clock_output_is_recovered)
    && link_check_reserved[3] |-> clock_output_hold)
    else $error("clock not held");
  a_flat_needs_loss: assert property (!$past(fast_signal_lost) |-> !clock_output_hold)
    else $error("clock held without loss");
  a_char_passes: assert property (
    $past(rst_n) && !$past(slow_tx_char_in.error)
    |-> slow_tx_char_out == $past(slow_tx_char_in.data))
    else $error("clean char altered");
endmodule
bind dsec_regs dsec_regs_checker i_chk (.*);
`default_nettype wire

// ==== testbench/dsec_host_model.sv ====
// management host model: one-cycle write and read strobes
`timescale 1ns/1ns
`default_nettype none
module dsec_host_model (
  input  wire logic                        clk_sys,
  input  wire dsec_pkg::dsec_mgmt_rsp_type mgmt_rsp,
  output dsec_pkg::dsec_mgmt_req_type      mgmt_req
);
  initial mgmt_req = '0;
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    mgmt_req <= '{1'b1, 1'b0, a, d};
    @(posedge clk_sys);
    mgmt_req <= '0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [15:0] d, output logic v);
    @(posedge clk_sys);
    mgmt_req <= '{1'b0, 1'b1, a, 16'h0000};
    @(posedge clk_sys);
    mgmt_req <= '0;
    #1;
    v = mgmt_rsp.valid;
    d = mgmt_rsp.rdata;
  endtask
  // read-modify-write so reserved bits keep what they hold
  task automatic ctrl(input logic [15:0] s, input logic [15:0] c);
    logic [15:0] d;
    logic        v;
    rd(16'h8021, d, v);
    wr(16'h8021, (d & ~c) | s);
  endtask
endmodule
`default_nettype wire

// ==== testbench/dsec_regs_tb_top.sv ====
// self-checking bench for the register bank
`timescale 1ns/1ns
`default_nettype none
module dsec_regs_tb_top;
  localparam logic [15:0] ADR [8] = '{16'h801C, 16'h801D, 16'h801E, 16'h801F,
                                      16'h8021, 16'h8026, 16'h8027, 16'h8028};
  localparam logic [15:0] RST [8] = '{16'h0000, 16'h01FC, 16'h0000, 16'h00C0,
                                      16'h000A, 16'h02FE, 16'h02FE, 16'h02FE};
  localparam logic [15:0] MSK [8] = '{16'hFFFF, 16'hFFFE, 16'hFFFF, 16'hFFFE,
                                      16'hFFFF, 16'h03FF, 16'h03FF, 16'h03FF};
  logic clk_sys = 0, rst_n = 0, pll = 0, los = 0, rec = 0, ready, hold;
  int err_count = 0, comparisons = 0;
  dsec_pkg::dsec_mgmt_req_type req;
  dsec_pkg::dsec_mgmt_rsp_type rsp;
  dsec_pkg::dsec_char_type     ci [3] = '{default: '0};
  logic [9:0]                  co [3];
  logic [31:0]                 seed, poly;
  logic [15:0]                 lcr;
  dsec_host_model i_host (.clk_sys(clk_sys), .mgmt_rsp(rsp), .mgmt_req(req));
  dsec_regs i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .mgmt_req(req), .mgmt_rsp(rsp),
    .fast_pll_locked(pll), .fast_signal_lost(los), .clock_output_is_recovered(rec),
    .slow_tx_char_in(ci[0]), .slow_rx_char_in(ci[1]), .fast_rx_char_in(ci[2]),
    .slow_tx_char_out(co[0]), .slow_rx_char_out(co[1]), .fast_rx_char_out(co[2]),
    .rx_descrambler_seed(seed), .rx_descrambler_polynomial(poly), .fast_link_ready(ready),
    .clock_output_hold(hold), .link_check_reserved(lcr));
  initial forever #5 clk_sys = ~clk_sys;
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rchk(input logic [15:0] a, input logic [15:0] e);
    logic [15:0] d;
    logic        v;
    i_host.rd(a, d, v);
    chk("valid", 1, v);
    chk("rdata", e, d);
  endtask
  task automatic t_reset;
    for (int i = 0; i < 8; i++) rchk(ADR[i], RST[i]);
    chk("seed", 32'h000001FC, seed);
    chk("poly", 32'h000000C0, poly);
    chk("reserved", 32'h0000000A, lcr);
    $display("t_reset done");
  endtask
  task automatic t_masks;
    for (int i = 0; i < 8; i++) begin
      i_host.wr(ADR[i], 16'hFFFF);
      rchk(ADR[i], MSK[i]);
    end
    rchk(16'h8020, 16'h0000);
    chk("seed", 32'hFFFFFFFE, seed);
    chk("poly", 32'hFFFFFFFE, poly);
    chk("reserved", 32'h0000FFFF, lcr);
    i_host.wr(16'h801D, 16'h1234);
    $display("t_masks done");
  endtask
  task automatic st(input logic [15:0] s, input logic p, l, r, er, eh);
    i_host.ctrl(s, 16'h0068);
    pll <= p;
    los <= l;
    rec <= r;
    repeat (3) @(posedge clk_sys);
    #1;
    chk("ready", er, ready);
    chk("hold", eh, hold);
  endtask
  task automatic t_link;
    st(16'h0008, 0, 0, 0, 0, 0);
    st(16'h0008, 1, 0, 1, 1, 0);
    st(16'h0008, 1, 1, 1, 0, 1);
    st(16'h0068, 0, 1, 1, 1, 1);
    st(16'h0060, 0, 1, 1, 1, 0);
    st(16'h0040, 1, 1, 0, 0, 0);
    $display("t_link done");
  endtask
  task automatic t_chars;
    for (int k = 0; k < 3; k++) i_host.wr(ADR[5+k], 16'h0155 + 16'h0111 * k);
    @(posedge clk_sys);
    for (int k = 0; k < 3; k++) ci[k] <= '{1'b1, 10'h000};
    @(posedge clk_sys);
    for (int k = 0; k < 3; k++) ci[k] <= '{1'b0, 10'h0F0 + 10'(k)};
    #1;
    for (int k = 0; k < 3; k++) chk("err char", 10'h155 + 10'h111 * k, co[k]);
    @(posedge clk_sys);
    #1;
    for (int k = 0; k < 3; k++) chk("data", 10'h0F0 + k, co[k]);
    $display("t_chars done");
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    conclude();
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset();
    t_masks();
    t_link();
    t_chars();
    conclude();
  end
endmodule
`default_nettype wire
